//--- hw/branch_move_wake_decode.sv
// decode and execute of conditional branches, memory moves and wake enables
//
// What this block does
// - branch_carry_clear loads the 11-bit target into the pc when carry is 0, else pc increments.
// - branch_nonzero loads the target when the work nibble is nonzero, else pc increments.
// - branch_zero loads the target when the work nibble is zero, else pc increments.
// - branch_zero and branch_nonzero finish in one cycle whether taken or not.
// - load_work_from_memory copies the nibble at a 7-bit address into the work nibble in one cycle.
// - load_carry_from_memory copies bit 0 of the addressed nibble into carry and touches no other flag.
// - load_wake_enables takes an 8-bit immediate whose ones set the matching wake flags, bit 3 excepted (always 0), in one cycle.
// - with wake flag 0 set, a divider 0 overflow releases the pause.
// - with wake flag 1 set, a timer 0 underflow releases the pause.
// - with wake flag 2 set, any change on the change detect port releases the pause.
// - with wake flag 4 set, a falling edge on the external interrupt pin releases; bit 3 is unused.
// - with wake flag 5 set, a finished serial reception releases the pause.
// - with wake flag 6 set, a finished serial transmission releases the pause.
// - with wake flag 7 set, a timer 1 underflow releases the pause.
//
// Implementation choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`include "bmw_cfg.svh"

module branch_move_wake_decode
  import bmw_pkg::*;
#(
  parameter int PC_W     = 11,
  parameter int MEM_AW   = 7,
  parameter int PORT_W   = 4
) (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // wishbone classic slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [11:0]        wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  // instruction issue from fetch
  input  wire logic               instr_valid_i,
  input  wire logic [15:0]        instr_i,
  // pause release events
  input  wire logic               div0_overflow_i,
  input  wire logic               timer0_underflow_i,
  input  wire logic [PORT_W-1:0]  change_detect_port_i,
  input  wire logic               ext_int_i,
  input  wire logic               serial_rx_done_i,
  input  wire logic               serial_tx_done_i,
  input  wire logic               timer1_underflow_i,
  // core state
  output logic      [PC_W-1:0]    pc_o,
  output logic      [3:0]         work_nibble_register_o,
  output logic                    carry_flag_o,
  output logic      [7:0]         wake_enable_flags_o,
  output logic                    branch_taken_o,
  output logic                    wake_release_o
);

  localparam int MEM_DEPTH = 1 << MEM_AW;

  // the target field is fixed at 11 bits and the address field at 7
  if (PC_W != `TARGET_W) begin : g_bad_pc
    $error("pc width must match the 11-bit branch target");
  end
  if (MEM_AW != `MEM_ADDR_W) begin : g_bad_mem
    $error("data memory address must be 7 bits");
  end

  //////////////////////////////////////////////////////////////////////////////
  // address decode helpers, used by both the read and the write path

  function automatic logic is_mem(input logic [11:0] adr);
    is_mem = adr[`MEM_SEL_BIT];
  endfunction : is_mem

  function automatic logic [MEM_AW-1:0] mem_index(input logic [11:0] adr);
    mem_index = adr[MEM_AW+1:2];
  endfunction : mem_index

  //////////////////////////////////////////////////////////////////////////////
  // instruction decode

  op_e                op;
  logic [`TARGET_W-1:0] target;
  logic [MEM_AW-1:0]  instr_addr;
  logic [`IMM_W-1:0]  imm;

  // one clean class per word; anything else only advances the pc
  always_comb
  begin
    target     = instr_i[`TARGET_W-1:0];
    instr_addr = instr_i[MEM_AW-1:0];
    imm        = instr_i[`IMM_W-1:0];
    op         = OP_OTHER;
    if (instr_i[`BR_OPC_HI:`BR_OPC_LO] == `OPC_BRANCH_CARRY_CLEAR)
      op = OP_BRANCH_CARRY_CLEAR;
    else if (instr_i[`BR_OPC_HI:`BR_OPC_LO] == `OPC_BRANCH_NONZERO)
      op = OP_BRANCH_NONZERO;
    else if (instr_i[`BR_OPC_HI:`BR_OPC_LO] == `OPC_BRANCH_ZERO)
      op = OP_BRANCH_ZERO;
    else if (instr_i[`MOV_OPC_HI:`MOV_OPC_LO] == `OPC_LOAD_WORK)
      op = OP_LOAD_WORK;
    else if (instr_i[`MOV_OPC_HI:`MOV_OPC_LO] == `OPC_LOAD_CARRY)
      op = OP_LOAD_CARRY;
    else if (instr_i[`WAKE_OPC_HI:`WAKE_OPC_LO] == `OPC_LOAD_WAKE)
      op = OP_LOAD_WAKE;
  end

  //////////////////////////////////////////////////////////////////////////////
  // data memory, nibble wide; read asynchronously so a load is one cycle

  // no reset on the array: software must fill a word before a load reads it
  logic [3:0] data_mem [MEM_DEPTH];
  logic [3:0] mem_rd_nibble;
  logic       bus_req;
  logic       bus_wr;
  logic       mem_wr;

  assign mem_rd_nibble = data_mem[instr_addr];
  assign bus_req       = wb_cyc_i && wb_stb_i;
  // a write lands on the edge where the master sees ack
  assign bus_wr        = bus_req && wb_we_i && wb_ack_o && wb_sel_i[0];
  assign mem_wr        = bus_wr && is_mem(wb_adr_i);

  // memory array written only from the bus
  always_ff @(posedge clk_i)
  begin
    if (mem_wr)
      data_mem[mem_index(wb_adr_i)] <= wb_dat_i[3:0];
  end

  //////////////////////////////////////////////////////////////////////////////
  // core state: pc, work nibble, carry, wake enables

  logic [PC_W-1:0] next_pc;
  logic [3:0]      next_work;
  logic            next_carry;
  logic [7:0]      next_wake;
  logic            next_taken;
  logic [15:0]     retired;
  logic [15:0]     next_retired;
  op_e             last_op;
  op_e             next_last_op;
  logic            work_zero;

  // one zero test of the nibble, shared by both zero branches
  assign work_zero = (work_nibble_register_o == 4'h0);

  // bus writes fill in only where the instruction leaves a register alone
  always_comb
  begin
    next_pc      = pc_o;
    next_work    = work_nibble_register_o;
    next_carry   = carry_flag_o;
    next_wake    = wake_enable_flags_o;
    next_taken   = 1'b0;
    next_retired = retired;
    next_last_op = last_op;
    if (bus_wr && !is_mem(wb_adr_i))
    begin
      if (wb_adr_i == `OFS_WORK)
        next_work = wb_dat_i[3:0];
      if (wb_adr_i == `OFS_CARRY)
        next_carry = wb_dat_i[0];
    end
    // the instruction is applied after the bus write, so it wins a same-edge clash
    if (instr_valid_i)
    begin
      next_pc      = pc_o + {{(PC_W-1){1'b0}}, 1'b1};
      next_retired = retired + 16'h0001;
      next_last_op = op;
      unique case (op)
        OP_BRANCH_CARRY_CLEAR:
        begin
          if (!carry_flag_o)
          begin
            next_pc    = target;
            next_taken = 1'b1;
          end
        end
        OP_BRANCH_NONZERO:
        begin
          if (!work_zero)
          begin
            next_pc    = target;
            next_taken = 1'b1;
          end
        end
        OP_BRANCH_ZERO:
        begin
          if (work_zero)
          begin
            next_pc    = target;
            next_taken = 1'b1;
          end
        end
        OP_LOAD_WORK:
          next_work = mem_rd_nibble;
        OP_LOAD_CARRY:
          next_carry = mem_rd_nibble[0];
        OP_LOAD_WAKE:
          next_wake = imm & `WAKE_USED_MASK;
        OP_OTHER:
          next_pc = pc_o + {{(PC_W-1){1'b0}}, 1'b1};
      endcase
      // branches fall through with work and carry untouched
    end
  end

  // core registers; no reset-time sampling of any port
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pc_o                   <= `RST_PC;
      work_nibble_register_o <= `RST_WORK;
      carry_flag_o           <= `RST_CARRY;
      wake_enable_flags_o    <= `RST_WAKE;
      branch_taken_o         <= 1'b0;
      retired                <= `RST_COUNT;
      last_op                <= OP_OTHER;
    end
    else
    begin
      pc_o                   <= next_pc;
      work_nibble_register_o <= next_work;
      carry_flag_o           <= next_carry;
      wake_enable_flags_o    <= next_wake;
      branch_taken_o         <= next_taken;
      retired                <= next_retired;
      last_op                <= next_last_op;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // wishbone answer: ack one cycle after the request, dropped the next cycle

  logic        next_ack;
  logic [31:0] next_rdata;

  // unmapped reads return zero and still ack, so the master never hangs
  always_comb
  begin
    next_ack   = bus_req && !wb_ack_o;
    next_rdata = `DATA_ZERO;
    if (bus_req && !wb_ack_o && !wb_we_i)
    begin
      if (is_mem(wb_adr_i))
        next_rdata[3:0] = data_mem[mem_index(wb_adr_i)];
      else
      begin
        unique case (wb_adr_i)
          `OFS_PC:      next_rdata[PC_W-1:0] = pc_o;
          `OFS_WORK:    next_rdata[3:0]      = work_nibble_register_o;
          `OFS_CARRY:   next_rdata[0]        = carry_flag_o;
          `OFS_WAKE:    next_rdata[7:0]      = wake_enable_flags_o;
          `OFS_STATUS:  next_rdata[3:0]      = {branch_taken_o, last_op};
          `OFS_RETIRED: next_rdata[15:0]     = retired;
          default:      next_rdata           = `DATA_ZERO;
        endcase
      end
    end
  end

  // ack and read data registered together, so dat_o is valid exactly with ack
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `DATA_ZERO;
    end
    else
    begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pause release; the pause logic itself sits elsewhere and takes this pulse

  // the cause vector stays open; only the combined pulse leaves the block
  wake_release #(
    .SRC_W  (8),
    .PORT_W (PORT_W)
  ) u_wake_release (
    .clk_i                (clk_i),
    .rst_i                (rst_i),
    .wake_enable_flags_i  (wake_enable_flags_o),
    .div0_overflow_i      (div0_overflow_i),
    .timer0_underflow_i   (timer0_underflow_i),
    .change_detect_port_i (change_detect_port_i),
    .ext_int_i            (ext_int_i),
    .serial_rx_done_i     (serial_rx_done_i),
    .serial_tx_done_i     (serial_tx_done_i),
    .timer1_underflow_i   (timer1_underflow_i),
    .wake_release_o       (wake_release_o),
    .wake_cause_o         ()
  );

endmodule : branch_move_wake_decode

//--- hw/bmw_cfg.svh
// opcode patterns, register offsets, reset values and widths for the decoder
`ifndef BMW_CFG_SVH
`define BMW_CFG_SVH

// instruction word layout
`define INSTR_W          16
`define BR_OPC_HI        15
`define BR_OPC_LO        11
`define TARGET_W         11
`define MOV_OPC_HI       15
`define MOV_OPC_LO       7
`define MEM_ADDR_W       7
`define WAKE_OPC_HI      15
`define WAKE_OPC_LO      8
`define IMM_W            8

// opcode values
`define OPC_BRANCH_CARRY_CLEAR 5'h1A
`define OPC_BRANCH_NONZERO     5'h18
`define OPC_BRANCH_ZERO        5'h1C
`define OPC_LOAD_WORK          9'h09D
`define OPC_LOAD_CARRY         9'h0B0
`define OPC_LOAD_WAKE          8'h42

// wake source positions
`define WAKE_DIV0        0
`define WAKE_TIMER0      1
`define WAKE_CHANGE      2
`define WAKE_RESERVED    3
`define WAKE_EXT_INT     4
`define WAKE_SER_RX      5
`define WAKE_SER_TX      6
`define WAKE_TIMER1      7
`define WAKE_USED_MASK   8'hF7

// wishbone byte offsets
`define OFS_PC           12'h000
`define OFS_WORK         12'h004
`define OFS_CARRY        12'h008
`define OFS_WAKE         12'h00C
`define OFS_STATUS       12'h010
`define OFS_RETIRED      12'h014
`define OFS_MEM_BASE     12'h200
`define MEM_SEL_BIT      9

// reset values
`define RST_PC           11'h000
`define RST_WORK         4'h0
`define RST_CARRY        1'h0
`define RST_WAKE         8'h00
`define RST_COUNT        16'h0000
`define DATA_ZERO        32'h0000_0000

`endif

//--- hw/bmw_pkg.sv
// types shared by the branch, move and wake decoder
package bmw_pkg;

  // decoded instruction class
  typedef enum logic [2:0] {
    OP_OTHER,
    OP_BRANCH_CARRY_CLEAR,
    OP_BRANCH_NONZERO,
    OP_BRANCH_ZERO,
    OP_LOAD_WORK,
    OP_LOAD_CARRY,
    OP_LOAD_WAKE
  } op_e;

endpackage : bmw_pkg

//--- hw/wake_release.sv
// gates pause-release events with the wake enable flags
`timescale 1ns/1ps
`include "bmw_cfg.svh"

module wake_release
  import bmw_pkg::*;
#(
  parameter int SRC_W  = 8,
  parameter int PORT_W = 4
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic [SRC_W-1:0]  wake_enable_flags_i,
  input  wire logic              div0_overflow_i,
  input  wire logic              timer0_underflow_i,
  input  wire logic [PORT_W-1:0] change_detect_port_i,
  input  wire logic              ext_int_i,
  input  wire logic              serial_rx_done_i,
  input  wire logic              serial_tx_done_i,
  input  wire logic              timer1_underflow_i,
  output logic                   wake_release_o,
  output logic [SRC_W-1:0]       wake_cause_o
);

  if (SRC_W != 8) begin : g_bad_width
    $error("wake_release needs exactly eight sources");
  end

  logic [PORT_W-1:0] port_prev;
  logic [PORT_W-1:0] next_port_prev;
  logic              int_prev;
  logic              next_int_prev;
  logic              primed;
  logic              next_primed;
  logic [SRC_W-1:0]  src;
  logic [SRC_W-1:0]  gated;
  logic              next_wake_release;
  logic [SRC_W-1:0]  next_wake_cause;

  //////////////////////////////////////////////////////////////////////////////
  // raw event vector; edges need one sample of history, so neither edge source fires
  // until primed, which hides the reset value of the history flops
  always_comb
  begin
    src                      = '0;
    src[`WAKE_DIV0]          = div0_overflow_i;
    src[`WAKE_TIMER0]        = timer0_underflow_i;
    src[`WAKE_CHANGE]        = primed && (change_detect_port_i != port_prev);
    src[`WAKE_RESERVED]      = 1'b0;
    src[`WAKE_EXT_INT]       = primed && int_prev && !ext_int_i;
    src[`WAKE_SER_RX]        = serial_rx_done_i;
    src[`WAKE_SER_TX]        = serial_tx_done_i;
    src[`WAKE_TIMER1]        = timer1_underflow_i;
  end

  // each source passes only with its own enable flag
  for (genvar i = 0; i < SRC_W; i++) begin : g_gate
    assign gated[i] = src[i] & wake_enable_flags_i[i];
  end

  // history and release pulse
  always_comb
  begin
    next_port_prev    = change_detect_port_i;
    next_int_prev     = ext_int_i;
    next_primed       = 1'b1;
    next_wake_release = |gated;
    next_wake_cause   = gated;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      port_prev      <= '0;
      int_prev       <= 1'b0;
      primed         <= 1'b0;
      wake_release_o <= 1'b0;
      wake_cause_o   <= '0;
    end
    else
    begin
      port_prev      <= next_port_prev;
      int_prev       <= next_int_prev;
      primed         <= next_primed;
      wake_release_o <= next_wake_release;
      wake_cause_o   <= next_wake_cause;
    end
  end

endmodule : wake_release

//--- dv/bmw_checker.sv
// port assertions for the branch, move and wake decoder
`timescale 1ns/1ps
`include "bmw_cfg.svh"

module bmw_checker
  import bmw_pkg::*;
#(
  parameter int PC_W   = 11,
  parameter int MEM_AW = 7,
  parameter int PORT_W = 4
) (
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic              wb_ack_o,
  input wire logic              instr_valid_i,
  input wire logic [15:0]       instr_i,
  input wire logic              div0_overflow_i,
  input wire logic              timer0_underflow_i,
  input wire logic [PORT_W-1:0] change_detect_port_i,
  input wire logic              ext_int_i,
  input wire logic              serial_rx_done_i,
  input wire logic              serial_tx_done_i,
  input wire logic              timer1_underflow_i,
  input wire logic [PC_W-1:0]   pc_o,
  input wire logic [3:0]        work_nibble_register_o,
  input wire logic              carry_flag_o,
  input wire logic [7:0]        wake_enable_flags_o,
  input wire logic              branch_taken_o,
  input wire logic              wake_release_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers; a bus write landing on the same edge may move work or carry
  logic [4:0] opc;
  logic       quiet_bus;
  logic [7:0] pulses;
  assign opc       = instr_i[15:11];
  assign quiet_bus = !(wb_ack_o && wb_we_i);
  assign pulses    = {timer1_underflow_i, serial_tx_done_i, serial_rx_done_i, 3'b000,
                      timer0_underflow_i, div0_overflow_i};

  ////////////////////////////////////////////////////////////////////////////
  AST_BCC_TAKE: assert property (instr_valid_i && opc == `OPC_BRANCH_CARRY_CLEAR && !carry_flag_o
    |=> pc_o == $past(instr_i[10:0]) && branch_taken_o) else $error("carry clear jump missed");
  AST_BCC_SKIP: assert property (instr_valid_i && opc == `OPC_BRANCH_CARRY_CLEAR && carry_flag_o
    |=> pc_o == PC_W'($past(pc_o) + 1) && !branch_taken_o) else $error("carry set jump taken");
  AST_BNZ: assert property (instr_valid_i && opc == `OPC_BRANCH_NONZERO
    |=> branch_taken_o == ($past(work_nibble_register_o) != 4'h0)) else $error("nonzero jump");
  AST_BZ: assert property (instr_valid_i && opc == `OPC_BRANCH_ZERO |=> pc_o == (
    $past(work_nibble_register_o) == 4'h0 ? $past(instr_i[10:0]) : PC_W'($past(pc_o) + 1)))
    else $error("zero jump pc wrong");
  AST_KEEP: assert property (instr_valid_i && instr_i[15:14] == 2'b11 && !instr_i[11] && quiet_bus
    |=> $stable(work_nibble_register_o) && $stable(carry_flag_o) && $stable(wake_enable_flags_o))
    else $error("branch touched state");
  AST_LDC: assert property (instr_valid_i && instr_i[15:7] == `OPC_LOAD_CARRY && quiet_bus
    |=> $stable(work_nibble_register_o) && $stable(wake_enable_flags_o) && !branch_taken_o)
    else $error("carry load touched more");
  AST_WAKE_LD: assert property (instr_valid_i && instr_i[15:8] == `OPC_LOAD_WAKE
    |=> wake_enable_flags_o == ($past(instr_i[7:0]) & `WAKE_USED_MASK))
    else $error("wake flags wrong");
  AST_REL: assert property (|(wake_enable_flags_o & pulses) |=> wake_release_o)
    else $error("pulse did not release");
  AST_CHG: assert property (wake_enable_flags_o[2] && !$past(rst_i) && !$stable(change_detect_port_i)
    |=> wake_release_o) else $error("port change did not release");
  AST_FALL: assert property (wake_enable_flags_o[4] && !$past(rst_i) && $fell(ext_int_i)
    |=> wake_release_o) else $error("falling edge did not release");
  AST_QUIET: assert property (wake_enable_flags_o == 8'h00 |=> !wake_release_o)
    else $error("release with no source enabled");
  AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not one cycle");
endmodule : bmw_checker

bind branch_move_wake_decode bmw_checker #(.PC_W(PC_W), .MEM_AW(MEM_AW), .PORT_W(PORT_W)) i_chk (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o, .instr_valid_i, .instr_i,
  .div0_overflow_i, .timer0_underflow_i, .change_detect_port_i, .ext_int_i, .serial_rx_done_i,
  .serial_tx_done_i, .timer1_underflow_i, .pc_o, .work_nibble_register_o, .carry_flag_o,
  .wake_enable_flags_o, .branch_taken_o, .wake_release_o);

//--- dv/branch_move_wake_decode_test.sv
// self-checking bench for the branch, move and wake decoder
`timescale 1ns/1ps
`include "bmw_cfg.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end

module branch_move_wake_decode_test
  import bmw_pkg::*;
;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, instr_valid_i, ext_int_i;
  logic        div0_overflow_i, timer0_underflow_i, serial_rx_done_i, serial_tx_done_i;
  logic        timer1_underflow_i, carry_flag_o, branch_taken_o, wake_release_o;
  logic [11:0] wb_adr_i;
  logic [3:0]  wb_sel_i, change_detect_port_i, work_nibble_register_o;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [15:0] instr_i;
  logic [10:0] pc_o;
  logic [7:0]  wake_enable_flags_o;
  logic [4:0]  opc;
  int          error_cnt, total_checks, seed, pc_m, work_m, carry_m, flags_m, v, a, tk, ret_m;

  branch_move_wake_decode i_dut (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .instr_valid_i, .instr_i, .div0_overflow_i, .timer0_underflow_i,
    .change_detect_port_i, .ext_int_i, .serial_rx_done_i, .serial_tx_done_i,
    .timer1_underflow_i, .pc_o, .work_nibble_register_o, .carry_flag_o, .wake_enable_flags_o,
    .branch_taken_o, .wake_release_o);

  // free-running core clock, 4 ns
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one classic cycle; waits for ack under a bound, read data lands in rd
  task automatic wb_cycle(input logic we, input logic [11:0] adr, input logic [31:0] dat);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1)
    begin
      error_cnt++;
      $display("[ERR] %0t no ack from the slave", $time);
    end
  endtask : wb_cycle

  // issue one instruction, return once its results have settled
  task automatic exec(input logic [15:0] w);
    ret_m++;
    @(posedge clk_i);
    instr_valid_i <= 1'b1;
    instr_i       <= w;
    @(posedge clk_i);
    instr_valid_i <= 1'b0;
    #1;
  endtask : exec

  task automatic check_state();
    `CHK(pc_o, pc_m[10:0])
    `CHK(work_nibble_register_o, work_m[3:0])
    `CHK(carry_flag_o, carry_m[0])
    `CHK(wake_enable_flags_o, flags_m[7:0])
  endtask : check_state

  // one event on source i; bit 3 has no source and must stay silent
  task automatic fire(input int i);
    @(posedge clk_i);
    case (i)
      0: div0_overflow_i <= 1'b1;
      1: timer0_underflow_i <= 1'b1;
      2: change_detect_port_i <= ~change_detect_port_i;
      4: ext_int_i <= 1'b0;
      5: serial_rx_done_i <= 1'b1;
      6: serial_tx_done_i <= 1'b1;
      7: timer1_underflow_i <= 1'b1;
      default: ;
    endcase
    @(posedge clk_i);
    {div0_overflow_i, timer0_underflow_i, serial_rx_done_i} <= 3'b000;
    {serial_tx_done_i, timer1_underflow_i} <= 2'b00;
    ext_int_i <= 1'b1;
    #1;
    `CHK(wake_release_o, flags_m[i])
  endtask : fire

  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////////////////
  // watchdog: the tests need well under 2000 cycles
  initial
  begin
    #40000;
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    report_and_stop();
  end

  initial
  begin
    seed = 11172;
    {wb_cyc_i, wb_stb_i, wb_we_i, instr_valid_i, div0_overflow_i} = 5'b00000;
    {timer0_underflow_i, serial_rx_done_i, serial_tx_done_i, timer1_underflow_i} = 4'b0000;
    {wb_adr_i, wb_dat_i, instr_i, change_detect_port_i} = '0;
    wb_sel_i = 4'hF;
    ext_int_i = 1'b1;
    {pc_m, work_m, carry_m, flags_m, ret_m} = '0;
    rst_i = 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    check_state();
    // reset values, and an unmapped word that reads zero
    for (int j = 0; j < 5; j++)
    begin
      wb_cycle(1'b0, (j == 4) ? 12'h01C : 12'(j * 4), 32'h0000_FFFF);
      `CHK(rd, `DATA_ZERO)
    end
    $display("test reset done");
    // memory loads into work and carry at random places
    for (int k = 0; k < 6; k++)
    begin
      a = $random(seed) & 127;
      v = $random(seed) & 15;
      wb_cycle(1'b1, `OFS_MEM_BASE | 12'(a << 2), 32'(v));
      wb_cycle(1'b0, `OFS_MEM_BASE | 12'(a << 2), 32'h0000_0000);
      `CHK(rd, 32'(v))
      exec({`OPC_LOAD_WORK, 7'(a)});
      work_m = v;
      pc_m = (pc_m + 1) % 2048;
      check_state();
      exec({`OPC_LOAD_CARRY, 7'(a)});
      carry_m = v & 1;
      pc_m = (pc_m + 1) % 2048;
      check_state();
    end
    $display("test loads done");
    // every branch against zero/nonzero work and clear/set carry
    for (int k = 0; k < 12; k++)
    begin
      work_m = ((k / 3) % 2) ? (($random(seed) & 15) | 1) : 0;
      carry_m = k / 6;
      wb_cycle(1'b1, `OFS_WORK, 32'(work_m));
      wb_cycle(1'b1, `OFS_CARRY, 32'(carry_m));
      v = $random(seed) & 2047;
      opc = (k % 3 == 0) ? `OPC_BRANCH_CARRY_CLEAR :
            (k % 3 == 1) ? `OPC_BRANCH_NONZERO : `OPC_BRANCH_ZERO;
      tk = (k % 3 == 0) ? (carry_m == 0) : (k % 3 == 1) ? (work_m != 0) : (work_m == 0);
      exec({opc, 11'(v)});
      pc_m = tk ? v : (pc_m + 1) % 2048;
      `CHK(branch_taken_o, 1'(tk))
      check_state();
    end
    $display("test branches done");
    // wake flags: random, complement, all ones, all zeros
    for (int r = 0; r < 4; r++)
    begin
      v = (r == 0) ? $random(seed) : (r == 1) ? ~v : (r == 2) ? 255 : 0;
      v &= 255;
      exec({`OPC_LOAD_WAKE, 8'(v)});
      flags_m = v & `WAKE_USED_MASK;
      pc_m = (pc_m + 1) % 2048;
      check_state();
      for (int i = 0; i < 8; i++)
        fire(i);
    end
    $display("test wake done");
    // status holds the last decoded class; an unknown word only steps the pc
    wb_cycle(1'b0, `OFS_STATUS, `DATA_ZERO);
    `CHK(rd, 32'(OP_LOAD_WAKE))
    exec(16'h0000);
    pc_m = (pc_m + 1) % 2048;
    check_state();
    wb_cycle(1'b0, `OFS_RETIRED, `DATA_ZERO);
    `CHK(rd, 32'(ret_m))
    $display("test status done");
    report_and_stop();
  end
endmodule : branch_move_wake_decode_test
